/* File: hw/udbp_defines.vh */
// Register map, field positions and reset values of the serial data buffer path
`ifndef UDBP_DEFINES_VH
`define UDBP_DEFINES_VH
`define UDBP_ADDR_RXBUF 12'h000
`define UDBP_ADDR_TXSH 12'h004
`define UDBP_ADDR_CTRL 12'h008
`define UDBP_ADDR_STAT 12'h00C
`define UDBP_ADDR_IMASK 12'h010
`define UDBP_CTRL_POWER 0
`define UDBP_CTRL_TXEN 1
`define UDBP_CTRL_RXEN 2
`define UDBP_CTRL_LEN7 3
`define UDBP_ST_TXDONE 0
`define UDBP_ST_RXRDY 1
`define UDBP_ST_OVR 2
`define UDBP_ST_TXBUSY 3
`define UDBP_NEVT 3
`define UDBP_DATA_RESET 8'hFF
`define UDBP_DIV_DEFAULT 16'h0364
`define UDBP_ADDR_DIV 12'h014
`define UDBP_LAST7 3'h6
`define UDBP_LAST8 3'h7
`endif

/* File: hw/udbp_top.v */
// Serial data buffer path: receive shifter, receive buffer, transmit shifter, APB slave
`timescale 1ns/1ns
`default_nettype none
`include "udbp_defines.vh"
module udbp_top #(
    parameter DIV_W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire serial_in_pin_i,
    output reg serial_out_pin_o,
    output reg irq_o
);
    localparam ST_IDLE = 2'b00;
    localparam ST_START = 2'b01;
    localparam ST_DATA = 2'b10;
    localparam ST_STOP = 2'b11;

    reg [7:0] receive_buffer_r;
    reg [7:0] transmit_shift_r;
    reg [3:0] ctrl_r;
    reg [DIV_W-1:0] div_r;
    reg [`UDBP_NEVT-1:0] stat_r;
    reg [`UDBP_NEVT-1:0] mask_r;
    reg rx_meta_r;
    reg rx_sync_r;
    // Receiver
    reg [1:0] rx_state_r;
    reg [DIV_W-1:0] rx_cnt_r;
    reg [2:0] rx_bit_r;
    reg [7:0] receive_shifter_r;
    // Transmitter
    reg [1:0] tx_state_r;
    reg [DIV_W-1:0] tx_cnt_r;
    reg [2:0] tx_bit_r;
    reg [7:0] tx_sh_r;

    wire power_w = ctrl_r[`UDBP_CTRL_POWER];
    wire txen_w = ctrl_r[`UDBP_CTRL_TXEN];
    wire rxen_w = ctrl_r[`UDBP_CTRL_RXEN];
    wire len7_w = ctrl_r[`UDBP_CTRL_LEN7];
    wire access_w = psel_i & penable_i;
    wire wr_w = access_w & pwrite_i;
    wire rd_w = access_w & ~pwrite_i;
    function hit;
        input [11:0] a;
        input [11:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // Index of the last data bit of a character, seven or eight bits long
    function [2:0] last_index;
        input seven;
        begin
            last_index = seven ? `UDBP_LAST7 : `UDBP_LAST8;
        end
    endfunction

    // A bit-time counter has run out when it reaches zero
    function cnt_zero;
        input [DIV_W-1:0] c;
        begin
            cnt_zero = (c == {DIV_W{1'b0}});
        end
    endfunction

    wire [2:0] last_bit_w = last_index(len7_w);
    // Register strobes: setup_w valid in the APB setup cycle, the write strobes in the access cycle
    wire setup_w = psel_i & ~penable_i;
    wire wr_ctrl_w = wr_w & hit(paddr_i, `UDBP_ADDR_CTRL);
    wire wr_mask_w = wr_w & hit(paddr_i, `UDBP_ADDR_IMASK);
    wire wr_div_w = wr_w & hit(paddr_i, `UDBP_ADDR_DIV);
    wire wr_stat_w = wr_w & hit(paddr_i, `UDBP_ADDR_STAT);
    // Bit-time ticks and frame positions
    wire rx_tick_w = cnt_zero(rx_cnt_r);
    wire tx_tick_w = cnt_zero(tx_cnt_r);
    wire rx_last_w = (rx_bit_r == last_bit_w);
    wire tx_last_w = (tx_bit_r == last_bit_w);
    wire tx_busy_w = (tx_state_r != ST_IDLE);
    // Receiver wakes on a low line, sampled after the synchroniser
    wire rx_start_w = rxen_w & ~rx_sync_r;

    wire wr_tx_w = wr_w & hit(paddr_i, `UDBP_ADDR_TXSH);
    wire tx_go_w = wr_tx_w & power_w & txen_w & (tx_state_r == ST_IDLE);
    wire tx_done_w = (tx_state_r == ST_STOP) && tx_tick_w;
    wire rx_frame_w = (rx_state_r == ST_STOP) && rx_tick_w;
    // A byte that completes while the last one is unread is an overrun
    wire rx_ovr_w = rx_frame_w & stat_r[`UDBP_ST_RXRDY];
    wire rx_ready_w = rx_frame_w & ~rx_ovr_w;
    wire rd_rxbuf_w = rd_w & hit(paddr_i, `UDBP_ADDR_RXBUF);
    wire [`UDBP_NEVT-1:0] evt_w = {rx_ovr_w, rx_ready_w, tx_done_w};
    wire [`UDBP_NEVT-1:0] w1c_w =
        wr_stat_w ? pwdata_i[`UDBP_NEVT-1:0] : {`UDBP_NEVT{1'b0}};
    // Reading the receive buffer retires the ready flag
    wire [`UDBP_NEVT-1:0] rdclr_w = {1'b0, rd_rxbuf_w, 1'b0};

    // Next status: hardware events win over a software clear in the same cycle
    reg [`UDBP_NEVT-1:0] stat_nxt;
    always @* begin
        stat_nxt = (stat_r & ~w1c_w & ~rdclr_w) | evt_w;
        if (~power_w)
            stat_nxt = {`UDBP_NEVT{1'b0}};
    end

    // Read data is picked in the setup cycle and stands through the access cycle
    reg [31:0] rdata_nxt;
    reg rderr_nxt;
    always @* begin
        rdata_nxt = 32'h0000_0000;
        rderr_nxt = 1'b0;
        if (hit(paddr_i, `UDBP_ADDR_RXBUF))
            rdata_nxt = {24'h000000, receive_buffer_r};
        else if (hit(paddr_i, `UDBP_ADDR_TXSH))
            rdata_nxt = 32'h0000_0000;
        else if (hit(paddr_i, `UDBP_ADDR_CTRL))
            rdata_nxt = {28'h0000000, ctrl_r};
        else if (hit(paddr_i, `UDBP_ADDR_STAT))
            rdata_nxt = {28'h0000000, tx_busy_w, stat_r};
        else if (hit(paddr_i, `UDBP_ADDR_IMASK))
            rdata_nxt = {29'h00000000, mask_r};
        else if (hit(paddr_i, `UDBP_ADDR_DIV))
            rdata_nxt = {{(32-DIV_W){1'b0}}, div_r};
        else
            rderr_nxt = ~pwrite_i;
    end

    // Next receive shifter; in seven-bit mode the last bit lands in bit 6
    reg [7:0] rx_shift_nxt;
    always @* begin
        rx_shift_nxt = {rx_sync_r, receive_shifter_r[7:1]};
        if (len7_w && rx_last_w)
            rx_shift_nxt = {1'b0, rx_sync_r, receive_shifter_r[7:2]};
    end

    // Next transmit line level; the line rests high outside frames
    reg tx_pin_nxt;
    always @* begin
        tx_pin_nxt = serial_out_pin_o;
        case (tx_state_r)
        ST_IDLE: begin
            if (tx_go_w)
                tx_pin_nxt = 1'b0;
        end
        ST_START: begin
            if (tx_tick_w)
                tx_pin_nxt = tx_sh_r[0];
        end
        ST_DATA: begin
            if (tx_tick_w)
                tx_pin_nxt = tx_last_w ? 1'b1 : tx_sh_r[1];
        end
        default: tx_pin_nxt = 1'b1;
        endcase
    end

    // Data leaves LSB first; ones fill in behind so the stop level follows
    reg [7:0] tx_shift_nxt;
    always @* begin
        tx_shift_nxt = tx_sh_r;
        if (tx_go_w)
            tx_shift_nxt = pwdata_i[7:0];
        else if ((tx_state_r == ST_DATA) && tx_tick_w)
            tx_shift_nxt = {1'b1, tx_sh_r[7:1]};
    end

    // Pin synchroniser
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= serial_in_pin_i;
            rx_sync_r <= rx_meta_r;
        end
    end

    // APB slave, control registers and status
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= 4'h0;
            div_r <= `UDBP_DIV_DEFAULT;
            mask_r <= {`UDBP_NEVT{1'b0}};
            stat_r <= {`UDBP_NEVT{1'b0}};
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            pready_o <= setup_w;
            pslverr_o <= setup_w & rderr_nxt;
            stat_r <= stat_nxt;
            irq_o <= |(stat_nxt & mask_r);
            if (setup_w)
                prdata_o <= rdata_nxt;
            if (wr_ctrl_w)
                ctrl_r <= pwdata_i[3:0];
            if (wr_mask_w)
                mask_r <= pwdata_i[`UDBP_NEVT-1:0];
            if (wr_div_w)
                div_r <= pwdata_i[DIV_W-1:0];
        end
    end

    // Receive path
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state_r <= ST_IDLE;
            rx_cnt_r <= {DIV_W{1'b0}};
            rx_bit_r <= 3'h0;
            receive_shifter_r <= 8'h00;
            receive_buffer_r <= `UDBP_DATA_RESET;
        end else if (~power_w) begin
            rx_state_r <= ST_IDLE;
            rx_cnt_r <= {DIV_W{1'b0}};
            rx_bit_r <= 3'h0;
            receive_buffer_r <= `UDBP_DATA_RESET;
        end else begin
            if (rx_cnt_r != {DIV_W{1'b0}})
                rx_cnt_r <= rx_cnt_r - 1'b1;
            case (rx_state_r)
            ST_IDLE: begin
                // Half a bit time centres the samples on each bit
                if (rx_start_w) begin
                    rx_state_r <= ST_START;
                    rx_cnt_r <= {1'b0, div_r[DIV_W-1:1]};
                end
            end
            ST_START: begin
                if (rx_cnt_r == {DIV_W{1'b0}}) begin
                    // Line high again at mid start bit: a glitch, not a frame
                    if (rx_sync_r) begin
                        rx_state_r <= ST_IDLE;
                    end else begin
                        rx_state_r <= ST_DATA;
                        rx_cnt_r <= div_r;
                        rx_bit_r <= 3'h0;
                    end
                end
            end
            ST_DATA: begin
                if (rx_cnt_r == {DIV_W{1'b0}}) begin
                    receive_shifter_r <= rx_shift_nxt;
                    rx_cnt_r <= div_r;
                    rx_bit_r <= rx_bit_r + 3'h1;
                    if (rx_last_w)
                        rx_state_r <= ST_STOP;
                end
            end
            ST_STOP: begin
                if (rx_cnt_r == {DIV_W{1'b0}}) begin
                    rx_state_r <= ST_IDLE;
                    // Overrun keeps the old byte and drops the new one
                    if (~rx_ovr_w)
                        receive_buffer_r <= receive_shifter_r;
                end
            end
            default: rx_state_r <= ST_IDLE;
            endcase
        end
    end

    // Transmit path
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_state_r <= ST_IDLE;
            tx_cnt_r <= {DIV_W{1'b0}};
            tx_bit_r <= 3'h0;
            tx_sh_r <= 8'hFF;
            transmit_shift_r <= `UDBP_DATA_RESET;
            serial_out_pin_o <= 1'b1;
        end else if (~power_w | ~txen_w) begin
            // Power off or transmit disable aborts a frame; line parked high
            tx_state_r <= ST_IDLE;
            tx_cnt_r <= {DIV_W{1'b0}};
            tx_bit_r <= 3'h0;
            transmit_shift_r <= `UDBP_DATA_RESET;
            serial_out_pin_o <= 1'b1;
        end else begin
            serial_out_pin_o <= tx_pin_nxt;
            tx_sh_r <= tx_shift_nxt;
            if (tx_cnt_r != {DIV_W{1'b0}})
                tx_cnt_r <= tx_cnt_r - 1'b1;
            case (tx_state_r)
            ST_IDLE: begin
                if (tx_go_w) begin
                    transmit_shift_r <= pwdata_i[7:0];
                    tx_state_r <= ST_START;
                    tx_cnt_r <= div_r;
                end
            end
            ST_START: begin
                if (tx_tick_w) begin
                    tx_state_r <= ST_DATA;
                    tx_cnt_r <= div_r;
                    tx_bit_r <= 3'h0;
                end
            end
            ST_DATA: begin
                if (tx_tick_w) begin
                    tx_cnt_r <= div_r;
                    tx_bit_r <= tx_bit_r + 3'h1;
                    if (tx_last_w)
                        tx_state_r <= ST_STOP;
                end
            end
            ST_STOP: begin
                if (tx_cnt_r == {DIV_W{1'b0}})
                    tx_state_r <= ST_IDLE;
            end
            default: tx_state_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: test/udbp_monitor.sv */
// Port checker for the serial data buffer path
`timescale 1ns/1ns
`default_nettype none
`include "udbp_defines.vh"
module udbp_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire serial_out_pin_o,
    input wire irq_o
);
    logic [3:0] ctl_r;
    logic [2:0] msk_r;
    wire wr_acc = psel_i && penable_i && pwrite_i && pready_o;
    wire rd_buf = pready_o && !pwrite_i && paddr_i == `UDBP_ADDR_RXBUF;
    // Shadow copies of control and mask, taken from bus writes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_r <= 4'h0;
            msk_r <= 3'h0;
        end else if (wr_acc && paddr_i == `UDBP_ADDR_CTRL) begin
            ctl_r <= pwdata_i[3:0];
        end else if (wr_acc && paddr_i == `UDBP_ADDR_IMASK) begin
            msk_r <= pwdata_i[2:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_tx_wr;
        pready_o && pwrite_i && paddr_i == `UDBP_ADDR_TXSH && ctl_r[1:0] == 2'h3;
    endsequence
    sequence s_start_bit;
        ##[1:3] !serial_out_pin_o;
    endsequence
    chk_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no answer in access phase");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    chk_err_mapped: assert property (pready_o && paddr_i <= 12'h014 && paddr_i[1:0] == 2'h0
        |-> !pslverr_o)
        else $error("error on mapped address");
    chk_tx_unread: assert property (pready_o && !pwrite_i && paddr_i == `UDBP_ADDR_TXSH
        |-> prdata_o == 32'h0)
        else $error("transmit register readable");
    chk_len7_msb: assert property (rd_buf && ctl_r[0] && ctl_r[3] |-> !prdata_o[7])
        else $error("msb set in seven bit mode");
    chk_off_ones: assert property (rd_buf && !ctl_r[0] |-> prdata_o[7:0] == 8'hFF)
        else $error("buffer not ones while off");
    chk_tx_start: assert property (s_tx_wr |-> s_start_bit)
        else $error("no start bit after write");
    chk_irq_masked: assert property ((msk_r == 3'h0) [*3] |-> !irq_o)
        else $error("interrupt while masked");
endmodule
bind udbp_top udbp_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .serial_out_pin_o(serial_out_pin_o), .irq_o(irq_o));
`default_nettype wire

/* File: test/udbp_peer.sv */
// Serial peer: drives the receive line and decodes the transmit line
`timescale 1ns/1ns
`default_nettype none
module udbp_peer #(
    parameter int BT = 5
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    int nbits = 8;
    logic [7:0] got = 8'h00;
    initial line_o = 1'b1;
    // Start bit, data LSB first, one stop bit; line idles high
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < nbits + 2; i++) begin
            line_o <= (i == 0) ? 1'b0 : (i > nbits) ? 1'b1 : b[i-1];
            repeat (BT) @(posedge clk_i);
        end
    endtask
    // Samples each bit near its middle
    always begin
        @(negedge line_i);
        repeat (BT / 2) @(posedge clk_i);
        got = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            repeat (BT) @(posedge clk_i);
            got[i] = line_i;
        end
        repeat (BT) @(posedge clk_i);
    end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench: register access over APB and serial traffic via the peer
`timescale 1ns/1ns
`default_nettype none
`include "udbp_defines.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, rx_line, tx_line, irq;
    int bad_count = 0;
    int n_compared = 0;
    udbp_top dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .serial_in_pin_i(rx_line),
        .serial_out_pin_o(tx_line), .irq_o(irq));
    udbp_peer #(.BT(5)) peer (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
    initial forever #5 clk_i = ~clk_i;
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 400) begin
            bad_count++;
            test_done();
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(`UDBP_ADDR_RXBUF, 32'hFF);
        rd_chk(`UDBP_ADDR_TXSH, 32'h0);
        bus(1'b0, 12'h020, 32'h0);
        `CHK(err, 1'b1)
        bus(1'b1, 12'h020, 32'h0);
        `CHK(err, 1'b0)
        bus(1'b1, `UDBP_ADDR_RXBUF, 32'h5A);
        rd_chk(`UDBP_ADDR_RXBUF, 32'hFF);
        bus(1'b1, `UDBP_ADDR_DIV, 32'h4);
        bus(1'b1, `UDBP_ADDR_IMASK, 32'h7);
        bus(1'b1, `UDBP_ADDR_CTRL, 32'h7);
        bus(1'b1, `UDBP_ADDR_TXSH, 32'hA5);
        wait_irq();
        `CHK(peer.got, 8'hA5)
        `CHK(tx_line, 1'b1)
        rd_chk(`UDBP_ADDR_STAT, 32'h1);
        bus(1'b1, `UDBP_ADDR_STAT, 32'h7);
        peer.send(8'h3C);
        wait_irq();
        rd_chk(`UDBP_ADDR_STAT, 32'h2);
        rd_chk(`UDBP_ADDR_RXBUF, 32'h3C);
        peer.send(8'h11);
        peer.send(8'h22);
        repeat (4) @(posedge clk_i);
        rd_chk(`UDBP_ADDR_STAT, 32'h6);
        bus(1'b1, `UDBP_ADDR_IMASK, 32'h0);
        rd_chk(`UDBP_ADDR_RXBUF, 32'h11);
        `CHK(irq, 1'b0)
        bus(1'b1, `UDBP_ADDR_IMASK, 32'h7);
        bus(1'b1, `UDBP_ADDR_STAT, 32'h7);
        bus(1'b1, `UDBP_ADDR_CTRL, 32'hF);
        `CHK(irq, 1'b0)
        peer.nbits = 7;
        peer.send(8'hFF);
        wait_irq();
        rd_chk(`UDBP_ADDR_RXBUF, 32'h7F);
        bus(1'b1, `UDBP_ADDR_CTRL, 32'h0);
        rd_chk(`UDBP_ADDR_RXBUF, 32'hFF);
        test_done();
    end
endmodule
`default_nettype wire
